// ---- core/rsm_consts.vh ----
// constants for the reference select and operating mode block
// What this block does
// - force code 0 or f selects automatic
// - four-bit priority per input; zero excludes
// - priorities 1 to 15, lower wins
// - equal priorities queue fifo, no switch
// - channel index breaks ties only between inputs qualifying in the same cycle
// - revertive ignores equal priorities
// - ultra-fast: few missed edges fail reference
// - failure interrupts instead of or with switch
// - test output mirrors failure flag if enabled
// - fast switching uses inputs one, two only
// - pin high through strap window latches mode
// - pin high: input one; low: input two
// - pin-latched mode sets 80 ppm tolerances
// - fast mode: monitors off, reads locked
// - automatic state control, forced optional
// - free-run to pre-locked on selection
// - no lock in 100 s: free-run
// - locked after one second of lock
// - lost-phase over 100 s: phase alarm
// - then pre-locked2 with standby, else holdover
// - locked, lost-phase, pre-locked2: holdover when no valid source remains
// - manual holdover bit picks manual control
// - force codes 3, 4, 8, 9; reset all ones
// - revertive: higher priority input takes over
// - automatic: selected source failure switches; no-switch bit blocks ultra-fast
// - holdover to pre-locked2 on new source
`ifndef RSM_CONSTS_VH
`define RSM_CONSTS_VH
// ***************************************
// register offsets
// ***************************************
`define RSM_A_INT 8'h06
`define RSM_A_OPS 8'h09
`define RSM_A_PRI_A 8'h19
`define RSM_A_PRI_B 8'h1b
`define RSM_A_PRI_C 8'h1c
`define RSM_A_FORCE 8'h33
`define RSM_A_MODE 8'h34
`define RSM_A_CAL_L 8'h3c
`define RSM_A_CAL_H 8'h3d
`define RSM_A_TOL1 8'h41
`define RSM_A_TOL2 8'h42
`define RSM_A_MON 8'h48
// ***************************************
// field positions
// ***************************************
`define RSM_INT_REF_FAIL 6
`define RSM_INT_PHASE 7
`define RSM_MON_FAST 4
`define RSM_MON_ULTRA 5
`define RSM_MON_TDO 6
`define RSM_MON_NOSW 7
`define RSM_MODE_REVERT 0
`define RSM_MODE_FSTATE 3
`define RSM_MODE_MANHO 4
// ***************************************
// codes and reset values
// ***************************************
`define RSM_FORCE_AUTO0 4'h0
`define RSM_FORCE_AUTO1 4'hf
`define RSM_FORCE_IN1 4'h3
`define RSM_FORCE_IN2 4'h4
`define RSM_FORCE_IN3 4'h8
`define RSM_FORCE_IN4 4'h9
`define RSM_FORCE_RST 8'h0f
`define RSM_PRI_A_RST 8'h21
`define RSM_PRI_B_RST 8'h43
`define RSM_ZERO_RST 8'h00
`define RSM_TOL_80PPM 8'h50
`define RSM_ST_FREE 3'h1
`define RSM_ST_HOLD 3'h2
`define RSM_ST_LOCK 3'h4
`define RSM_ST_PRE2 3'h5
`define RSM_ST_PRE 3'h6
`define RSM_ST_LOST 3'h7
// ***************************************
// timing
// ***************************************
`define RSM_CLK_KHZ 250000
`define RSM_TICK_MS 1
`define RSM_STRAP_MS 251
`define RSM_ACQ_MS 100000
`define RSM_QUAL_MS 1000
`define RSM_UF_MISS 16
`endif

// ---- core/rsm_ref_select_mode_fsm.v ----
// reference source selection and operating mode state machine
`include "rsm_consts.vh"

module rsm_ref_select_mode_fsm #(
    parameter CW = 18,
    parameter TW = 17,
    parameter [31:0] TICK_CYC = `RSM_CLK_KHZ * `RSM_TICK_MS,
    parameter [31:0] STRAP_TICKS = `RSM_STRAP_MS / `RSM_TICK_MS,
    parameter [31:0] ACQ_TICKS = `RSM_ACQ_MS / `RSM_TICK_MS,
    parameter [31:0] QUAL_TICKS = `RSM_QUAL_MS / `RSM_TICK_MS,
    parameter [7:0] UF_MISS_CYC = `RSM_UF_MISS
) (
    // clock and reset
    input wire i_sys_clk,
    input wire i_reset,
    // register port
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [7:0] o_reg_rdata,
    // reference monitoring
    input wire [3:0] i_ref_valid,
    input wire [3:0] i_ref_edge,
    input wire i_phase_locked,
    input wire i_switch_select_pin,
    // selection and mode
    output reg [1:0] o_sel_ref,
    output reg o_sel_valid,
    output reg [2:0] o_op_state,
    output reg o_monitor_disable,
    output reg o_manual_holdover,
    output reg [3:0] o_phase_alarm,
    // test data output pin
    output reg o_tdo_flag,
    output reg o_tdo_flag_en,
    // frequency settings
    output reg [7:0] o_tol_one,
    output reg [7:0] o_tol_two,
    output reg [15:0] o_osc_cal
);

// ***************************************
// states and derived constants
// ***************************************
localparam [5:0] S_FREE = 6'h01;
localparam [5:0] S_PRE = 6'h02;
localparam [5:0] S_LOCK = 6'h04;
localparam [5:0] S_LOST = 6'h08;
localparam [5:0] S_PRE2 = 6'h10;
localparam [5:0] S_HOLD = 6'h20;
localparam [31:0] TICK_LAST32 = TICK_CYC - 1;
localparam [CW-1:0] TICK_LAST = TICK_LAST32[CW-1:0];
localparam [TW-1:0] STRAP_T = STRAP_TICKS[TW-1:0];
localparam [TW-1:0] ACQ_T = ACQ_TICKS[TW-1:0];
localparam [TW-1:0] QUAL_T = QUAL_TICKS[TW-1:0];
localparam [7:0] UF_LAST = UF_MISS_CYC - 8'h01;

function [2:0] code_of;
    input [5:0] st;
    begin
        case (st)
            S_FREE: code_of = `RSM_ST_FREE;
            S_PRE: code_of = `RSM_ST_PRE;
            S_LOCK: code_of = `RSM_ST_LOCK;
            S_LOST: code_of = `RSM_ST_LOST;
            S_PRE2: code_of = `RSM_ST_PRE2;
            S_HOLD: code_of = `RSM_ST_HOLD;
            default: code_of = `RSM_ST_FREE;
        endcase
    end
endfunction

function [5:0] st_of;
    input [2:0] code;
    begin
        case (code)
            `RSM_ST_PRE: st_of = S_PRE;
            `RSM_ST_LOCK: st_of = S_LOCK;
            `RSM_ST_LOST: st_of = S_LOST;
            `RSM_ST_PRE2: st_of = S_PRE2;
            `RSM_ST_HOLD: st_of = S_HOLD;
            default: st_of = S_FREE;
        endcase
    end
endfunction

// ***************************************
// registers
// ***************************************
reg [7:0] int_r;
reg [7:0] pri_a_r;
reg [7:0] pri_b_r;
reg [7:0] pri_c_r;
reg [7:0] force_r;
reg [7:0] mode_r;
reg [7:0] mon_r;
reg [5:0] state_r;
reg [5:0] state_nxt;
reg [CW-1:0] tick_cnt_r;
reg tick_r;
reg [TW-1:0] st_tmr_r;
reg [TW-1:0] lock_tmr_r;
reg [TW-1:0] strap_cnt_r;
reg strap_low_r;
reg strap_done_r;
reg strap_en_r;
reg [7:0] miss_r;
reg [3:0] uf_fail_r;
reg [3:0] qual_r;
reg [7:0] rank_r;
reg [7:0] rank_nxt;
reg [1:0] sel_nxt;
reg sel_v_nxt;
reg [1:0] best;
reg best_v;
reg [5:0] best_key;
reg timeout;
reg alarm_now;
reg [3:0] cnt;
integer i;
integer j;

wire [15:0] pri_all = {pri_b_r, pri_a_r};
wire fast_en = strap_en_r | mon_r[`RSM_MON_FAST];
wire wr_hit = i_reg_wr;
wire [3:0] fcode = force_r[3:0];
wire auto_sel = (fcode == `RSM_FORCE_AUTO0) ||
    (fcode == `RSM_FORCE_AUTO1);
wire strap_fire = tick_r & ~strap_done_r & (strap_cnt_r == STRAP_T);
wire uf_fail = mon_r[`RSM_MON_ULTRA] & o_sel_valid & ~fast_en &
    (miss_r == UF_LAST);
wire cur_qual = o_sel_valid & qual_r[o_sel_ref];
wire standby = |(qual_r & ~(4'h1 << o_sel_ref));

// ***************************************
// qualification and fifo rank
// ***************************************
reg [3:0] qual_nxt;
always @* begin
    for (i = 0; i < 4; i = i + 1) begin
        // zero priority excludes the input
        qual_nxt[i] = i_ref_valid[i] & (pri_all[4*i +: 4] != 4'h0) &
            ~o_phase_alarm[i] & ~uf_fail_r[i];
    end
end

always @* begin
    rank_nxt = rank_r;
    for (i = 0; i < 4; i = i + 1) begin
        cnt = 4'h0;
        if (qual_nxt[i] & ~qual_r[i]) begin
            // newcomer queues at the tail
            for (j = 0; j < 4; j = j + 1) begin
                if (j != i && qual_r[j] && qual_nxt[j])
                    cnt = cnt + 4'h1;
            end
            rank_nxt[2*i +: 2] = cnt[1:0];
        end else if (qual_nxt[i]) begin
            for (j = 0; j < 4; j = j + 1) begin
                if (qual_r[j] && !qual_nxt[j] &&
                    rank_r[2*j +: 2] < rank_r[2*i +: 2])
                    cnt = cnt + 4'h1;
            end
            rank_nxt[2*i +: 2] = rank_r[2*i +: 2] - cnt[1:0];
        end
    end
end

// ***************************************
// best candidate and next selection
// ***************************************
always @* begin
    best = 2'h0;
    best_v = 1'b0;
    best_key = 6'h3f;
    for (i = 0; i < 4; i = i + 1) begin
        // key: priority, then queue place
        if (qual_r[i] && (!best_v ||
            {pri_all[4*i +: 4], rank_r[2*i +: 2]} < best_key)) begin
            best = i[1:0];
            best_v = 1'b1;
            best_key = {pri_all[4*i +: 4], rank_r[2*i +: 2]};
        end
    end
end

always @* begin
    sel_nxt = o_sel_ref;
    sel_v_nxt = o_sel_valid;
    if (fast_en) begin
        sel_nxt = i_switch_select_pin ? 2'h0 : 2'h1;
        sel_v_nxt = 1'b1;
    end else if (!auto_sel) begin
        sel_v_nxt = 1'b1;
        case (fcode)
            `RSM_FORCE_IN1: sel_nxt = 2'h0;
            `RSM_FORCE_IN2: sel_nxt = 2'h1;
            `RSM_FORCE_IN3: sel_nxt = 2'h2;
            `RSM_FORCE_IN4: sel_nxt = 2'h3;
            default: begin
                sel_nxt = best;
                sel_v_nxt = best_v;
            end
        endcase
    end else if (!cur_qual) begin
        sel_nxt = best;
        sel_v_nxt = best_v;
    end else if (mode_r[`RSM_MODE_REVERT] && best_v &&
        best_key[5:2] < pri_all[4*o_sel_ref +: 4]) begin
        sel_nxt = best;
    end
end

// ***************************************
// operating mode state machine
// ***************************************
always @* begin
    timeout = tick_r & (st_tmr_r >= ACQ_T);
    alarm_now = 1'b0;
    state_nxt = state_r;
    case (state_r)
        S_FREE: begin
            if (o_sel_valid)
                state_nxt = S_PRE;
        end
        S_PRE: begin
            if (!o_sel_valid) begin
                state_nxt = S_FREE;
            end else if (lock_tmr_r >= QUAL_T) begin
                state_nxt = S_LOCK;
            end else if (timeout) begin
                alarm_now = 1'b1;
                state_nxt = S_FREE;
            end
        end
        S_LOCK: begin
            if (!o_sel_valid)
                state_nxt = S_HOLD;
            else if (!i_phase_locked)
                state_nxt = S_LOST;
        end
        S_LOST: begin
            if (!o_sel_valid) begin
                state_nxt = S_HOLD;
            end else if (lock_tmr_r >= QUAL_T) begin
                state_nxt = S_LOCK;
            end else if (timeout) begin
                alarm_now = 1'b1;
                state_nxt = standby ? S_PRE2 : S_HOLD;
            end
        end
        S_PRE2: begin
            if (!o_sel_valid) begin
                state_nxt = S_HOLD;
            end else if (lock_tmr_r >= QUAL_T) begin
                state_nxt = S_LOCK;
            end else if (timeout) begin
                alarm_now = 1'b1;
                state_nxt = S_HOLD;
            end
        end
        S_HOLD: begin
            if (o_sel_valid)
                state_nxt = S_PRE2;
        end
        default: state_nxt = S_FREE;
    endcase
    if (mode_r[`RSM_MODE_FSTATE])
        state_nxt = st_of(force_r[6:4]);
    if (fast_en) begin
        state_nxt = S_LOCK;
        alarm_now = 1'b0;
    end
end

// ***************************************
// timers, strap and failure tracking
// ***************************************
always @(posedge i_sys_clk) begin
    if (i_reset) begin
        tick_cnt_r <= {CW{1'b0}};
        tick_r <= 1'b0;
        st_tmr_r <= {TW{1'b0}};
        lock_tmr_r <= {TW{1'b0}};
        strap_cnt_r <= {TW{1'b0}};
        strap_low_r <= ~i_switch_select_pin;
        strap_done_r <= 1'b0;
        strap_en_r <= 1'b0;
        miss_r <= 8'h00;
        uf_fail_r <= 4'h0;
        qual_r <= 4'h0;
        rank_r <= 8'h00;
        state_r <= S_FREE;
    end else begin
        tick_r <= (tick_cnt_r == TICK_LAST);
        tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? {CW{1'b0}} :
            tick_cnt_r + {{(CW-1){1'b0}}, 1'b1};
        state_r <= state_nxt;
        qual_r <= qual_nxt;
        rank_r <= rank_nxt;
        if (state_nxt != state_r)
            st_tmr_r <= {TW{1'b0}};
        else if (tick_r && st_tmr_r != {TW{1'b1}})
            st_tmr_r <= st_tmr_r + {{(TW-1){1'b0}}, 1'b1};
        // lock needs an unbroken run
        if (!i_phase_locked || !o_sel_valid)
            lock_tmr_r <= {TW{1'b0}};
        else if (tick_r && lock_tmr_r != {TW{1'b1}})
            lock_tmr_r <= lock_tmr_r + {{(TW-1){1'b0}}, 1'b1};
        if (!i_switch_select_pin)
            strap_low_r <= 1'b1;
        if (tick_r && !strap_done_r)
            strap_cnt_r <= strap_cnt_r + {{(TW-1){1'b0}}, 1'b1};
        if (strap_fire) begin
            strap_done_r <= 1'b1;
            strap_en_r <= ~strap_low_r & i_switch_select_pin;
        end
        if (i_ref_edge[o_sel_ref] || sel_nxt != o_sel_ref)
            miss_r <= 8'h00;
        else if (miss_r != UF_LAST)
            miss_r <= miss_r + 8'h01;
        for (i = 0; i < 4; i = i + 1) begin
            if (i_ref_edge[i] || fast_en)
                uf_fail_r[i] <= 1'b0;
            else if (uf_fail && o_sel_ref == i[1:0] &&
                !mon_r[`RSM_MON_NOSW])
                uf_fail_r[i] <= 1'b1;
        end
    end
end

// ***************************************
// register file and outputs
// ***************************************
always @(posedge i_sys_clk) begin
    if (i_reset) begin
        int_r <= `RSM_ZERO_RST;
        pri_a_r <= `RSM_PRI_A_RST;
        pri_b_r <= `RSM_PRI_B_RST;
        pri_c_r <= `RSM_ZERO_RST;
        force_r <= `RSM_FORCE_RST;
        mode_r <= `RSM_ZERO_RST;
        mon_r <= `RSM_ZERO_RST;
        o_reg_rdata <= 8'h00;
        o_sel_ref <= 2'h0;
        o_sel_valid <= 1'b0;
        o_op_state <= `RSM_ST_FREE;
        o_monitor_disable <= 1'b0;
        o_manual_holdover <= 1'b0;
        o_phase_alarm <= 4'h0;
        o_tdo_flag <= 1'b0;
        o_tdo_flag_en <= 1'b0;
        o_tol_one <= `RSM_ZERO_RST;
        o_tol_two <= `RSM_ZERO_RST;
        o_osc_cal <= 16'h0000;
    end else begin
        o_sel_ref <= sel_nxt;
        o_sel_valid <= sel_v_nxt;
        o_op_state <= code_of(state_nxt);
        o_monitor_disable <= fast_en;
        o_manual_holdover <= mode_r[`RSM_MODE_MANHO];
        o_tdo_flag <= mon_r[`RSM_MON_TDO] & int_r[`RSM_INT_REF_FAIL];
        o_tdo_flag_en <= mon_r[`RSM_MON_TDO];
        if (wr_hit) begin
            case (i_reg_addr)
                `RSM_A_PRI_A: pri_a_r <= i_reg_wdata;
                `RSM_A_PRI_B: pri_b_r <= i_reg_wdata;
                `RSM_A_PRI_C: pri_c_r <= i_reg_wdata;
                `RSM_A_FORCE: force_r <= i_reg_wdata;
                `RSM_A_MODE: mode_r <= i_reg_wdata;
                `RSM_A_MON: mon_r <= i_reg_wdata;
                `RSM_A_CAL_L: o_osc_cal[7:0] <= i_reg_wdata;
                `RSM_A_CAL_H: o_osc_cal[15:8] <= i_reg_wdata;
                `RSM_A_TOL1: o_tol_one <= i_reg_wdata;
                `RSM_A_TOL2: o_tol_two <= i_reg_wdata;
                default: ;
            endcase
        end
        if (strap_fire && !strap_low_r && i_switch_select_pin) begin
            o_tol_one <= `RSM_TOL_80PPM;
            o_tol_two <= `RSM_TOL_80PPM;
        end
        // w1c; a same-cycle event wins
        int_r <= (int_r & ~((wr_hit && i_reg_addr == `RSM_A_INT) ?
            i_reg_wdata : 8'h00)) |
            ({7'h00, uf_fail} << `RSM_INT_REF_FAIL) |
            ({7'h00, alarm_now} << `RSM_INT_PHASE);
        for (i = 0; i < 4; i = i + 1) begin
            if (alarm_now && o_sel_ref == i[1:0])
                o_phase_alarm[i] <= 1'b1;
            else if (!i_ref_valid[i])
                o_phase_alarm[i] <= 1'b0;
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                `RSM_A_INT: o_reg_rdata <= int_r;
                `RSM_A_OPS: o_reg_rdata <= {5'h00, o_op_state};
                `RSM_A_PRI_A: o_reg_rdata <= pri_a_r;
                `RSM_A_PRI_B: o_reg_rdata <= pri_b_r;
                `RSM_A_PRI_C: o_reg_rdata <= pri_c_r;
                `RSM_A_FORCE: o_reg_rdata <= force_r;
                `RSM_A_MODE: o_reg_rdata <= mode_r;
                `RSM_A_MON: o_reg_rdata <= mon_r;
                `RSM_A_CAL_L: o_reg_rdata <= o_osc_cal[7:0];
                `RSM_A_CAL_H: o_reg_rdata <= o_osc_cal[15:8];
                `RSM_A_TOL1: o_reg_rdata <= o_tol_one;
                `RSM_A_TOL2: o_reg_rdata <= o_tol_two;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end
end

endmodule // rsm_ref_select_mode_fsm

// ---- bench/rsm_chk.sv ----
// port assertions for the reference select and mode block
module rsm_chk #(
    parameter [31:0] TICK_CYC = 250000,
    parameter [31:0] ACQ_TICKS = 100000,
    parameter [31:0] QUAL_TICKS = 1000
) (
    // clock and reset
    input wire i_sys_clk,
    input wire i_reset,
    // inputs watched
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_phase_locked,
    input wire i_switch_select_pin,
    // outputs watched
    input wire [1:0] o_sel_ref,
    input wire o_sel_valid,
    input wire [2:0] o_op_state,
    input wire o_monitor_disable,
    input wire o_manual_holdover,
    input wire o_tdo_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] lock_run_r;
    logic [31:0] stay_r;
    logic [2:0] st_q_r;
    logic clr;
    logic wr_mode;
    assign clr = i_reg_wr && (i_reg_addr == 8'h06 || i_reg_addr == 8'h48);
    assign wr_mode = i_reg_wr && i_reg_addr == 8'h34;
    // ***************************************
    // unbroken lock length and time in the current state
    // ***************************************
    always @(posedge i_sys_clk) begin
        st_q_r <= o_op_state;
        if (i_reset || !i_phase_locked) lock_run_r <= 32'h0;
        else lock_run_r <= lock_run_r + 32'h1;
        if (i_reset || o_op_state != st_q_r) stay_r <= 32'h0;
        else stay_r <= stay_r + 32'h1;
    end
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);
    // ***************************************
    // assertions
    // ***************************************
    tdo_hold_a: assert property (o_tdo_flag && !clr && !$past(clr) |=> o_tdo_flag)
        else $error("test output flag fell without a clear");
    manual_ho_a: assert property ((wr_mode ##1 !wr_mode) |-> ##1 o_manual_holdover == $past(i_reg_wdata[4], 2))
        else $error("manual holdover output differs from written bit");
    fast_locked_a: assert property (o_monitor_disable && $past(o_monitor_disable) |-> o_op_state == 3'h4)
        else $error("fast switching mode not reporting locked");
    fast_sel_hi_a: assert property ((o_monitor_disable && i_switch_select_pin) [*5] |-> o_sel_valid && o_sel_ref == 2'h0)
        else $error("pin high did not select input one");
    fast_sel_lo_a: assert property ((o_monitor_disable && !i_switch_select_pin) [*5] |-> o_sel_valid && o_sel_ref == 2'h1)
        else $error("pin low did not select input two");
    free_to_pre_a: assert property ($rose(o_sel_valid) && o_op_state == 3'h1 && !o_monitor_disable |=> o_op_state == 3'h6)
        else $error("selection in free-run did not enter pre-locked");
    lock_entry_a: assert property (o_op_state == 3'h4 && st_q_r != 3'h4 && !o_monitor_disable |-> lock_run_r >= (QUAL_TICKS - 1) * TICK_CYC && st_q_r inside {3'h5, 3'h6, 3'h7})
        else $error("locked entered without qualified lock");
    dwell_limit_a: assert property (o_op_state == 3'h6 || o_op_state == 3'h7 |-> stay_r <= ACQ_TICKS * TICK_CYC + 2 * TICK_CYC + 4)
        else $error("pre-locked or lost-phase outlived its timeout");
    lost_exit_a: assert property (st_q_r == 3'h7 && o_op_state != 3'h7 && !o_monitor_disable |-> o_op_state inside {3'h2, 3'h4, 3'h5})
        else $error("lost-phase left to an illegal state");
    cover property (o_op_state == 3'h4 && !o_monitor_disable);
    cover property (o_op_state == 3'h2);
    cover property (o_tdo_flag);
    cover property (o_monitor_disable && !i_switch_select_pin);
endmodule // rsm_chk

bind rsm_ref_select_mode_fsm rsm_chk #(
    .TICK_CYC(TICK_CYC),
    .ACQ_TICKS(ACQ_TICKS),
    .QUAL_TICKS(QUAL_TICKS)
) i_chk (
    .i_sys_clk, .i_reset, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_phase_locked, .i_switch_select_pin, .o_sel_ref, .o_sel_valid,
    .o_op_state, .o_monitor_disable, .o_manual_holdover, .o_tdo_flag
);

// ---- bench/rsm_src_model.sv ----
// model of the reference clock sources and the switch-select pin
module rsm_src_model (
    // clock and controls from the bench
    input wire logic i_clk,
    input wire logic [3:0] i_run,
    input wire logic i_pin,
    // toward the device
    output logic [3:0] o_ref_edge,
    output logic o_switch_select_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph_r = 3'h0;
    initial o_ref_edge = 4'h0;
    // each source edges every eight cycles, staggered; a stopped one is silent
    always @(negedge i_clk) begin
        ph_r <= ph_r + 3'h1;
        for (int i = 0; i < 4; i++) begin
            o_ref_edge[i] <= i_run[i] && ph_r == 3'(2 * i);
        end
    end
    // passes the bench pin level; high through reset and the strap window latches fast mode
    assign o_switch_select_pin = i_pin;
endmodule // rsm_src_model

// ---- bench/testbench.sv ----
// self-checking bench for the reference select and mode block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk, i_reset, i_reg_wr, i_reg_rd, i_phase_locked;
    logic i_switch_select_pin, o_sel_valid, o_monitor_disable, pin_lvl;
    logic o_manual_holdover, o_tdo_flag, o_tdo_flag_en;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_tol_one, o_tol_two;
    logic [3:0] i_ref_valid, i_ref_edge, o_phase_alarm, run;
    logic [2:0] o_op_state;
    logic [1:0] o_sel_ref;
    logic [15:0] o_osc_cal, pr;
    logic [7:0] rv;
    logic [7:0] ra [8] = '{8'h19, 8'h1b, 8'h1c, 8'h33, 8'h48, 8'h06, 8'h34, 8'h55};
    logic [7:0] re [8] = '{8'h21, 8'h43, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [3:0] fc [4] = '{4'h3, 4'h4, 4'h8, 4'h9};
    int errors, total_checks, cyc, seed, e;

    rsm_ref_select_mode_fsm #(.TICK_CYC(4), .STRAP_TICKS(3), .ACQ_TICKS(20),
        .QUAL_TICKS(5), .UF_MISS_CYC(16)) i_dut (
        .i_sys_clk, .i_reset, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
        .o_reg_rdata, .i_ref_valid, .i_ref_edge, .i_phase_locked,
        .i_switch_select_pin, .o_sel_ref, .o_sel_valid, .o_op_state,
        .o_monitor_disable, .o_manual_holdover, .o_phase_alarm, .o_tdo_flag,
        .o_tdo_flag_en, .o_tol_one, .o_tol_two, .o_osc_cal);
    rsm_src_model i_src (.i_clk(i_sys_clk), .i_run(run), .i_pin(pin_lvl),
        .o_ref_edge(i_ref_edge), .o_switch_select_pin(i_switch_select_pin));

    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc > 20000) begin
            errors++;
            print_verdict();
        end
    end
    // ***************************************
    // helpers
    // ***************************************
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_sys_clk);
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge i_sys_clk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_sys_clk);
        i_reg_rd = 1'b0;
        @(negedge i_sys_clk);
        rv = o_reg_rdata;
    endtask
    // 0: selection as {valid, index}, 1: state code
    function automatic logic [7:0] cur(input int w);
        if (w == 0) return {5'h0, o_sel_valid, o_sel_ref};
        return {5'h0, o_op_state};
    endfunction
    task automatic wt(input int w, input logic [7:0] x, input int n);
        int k;
        k = 0;
        while (cur(w) !== x && k < n) begin
            @(negedge i_sys_clk);
            k++;
        end
        chk(cur(w), x);
    endtask
    task automatic rst(input logic p);
        i_reset = 1'b1;
        pin_lvl = p;
        i_ref_valid = 4'h0;
        i_phase_locked = 1'b1;
        run = 4'hf;
        nap(12);
        i_reset = 1'b0;
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic nap(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    // unique lowest nonzero priority among valid inputs, else -1
    function automatic int best(input logic [15:0] p, input logic [3:0] v);
        int b, m, n;
        b = -1;
        m = 16;
        n = 0;
        for (int i = 0; i < 4; i++) begin
            if (v[i] && p[i*4+:4] != 4'h0 && p[i*4+:4] < m) begin
                m = p[i*4+:4];
                b = i;
                n = 1;
            end else if (v[i] && p[i*4+:4] == m) begin
                n++;
            end
        end
        return (n == 1) ? b : -1;
    endfunction
    // ***************************************
    // main sequence
    // ***************************************
    initial begin
        seed = 25;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        rst(1'b0);
        foreach (ra[i]) begin
            rd(ra[i]);
            chk(rv, re[i]);
        end
        chk(cur(1), 8'h1);
        done("reset");
        i_ref_valid = 4'h3;
        wt(0, 8'h4, 10);
        wt(1, 8'h6, 10);
        i_phase_locked = 1'b1;
        wt(1, 8'h4, 60);
        i_phase_locked = 1'b0;
        wt(1, 8'h7, 10);
        wt(1, 8'h5, 120);
        chk({4'h0, o_phase_alarm}, 8'h1);
        wt(0, 8'h5, 10);
        i_phase_locked = 1'b1;
        wt(1, 8'h4, 60);
        i_ref_valid = 4'h0;
        wt(1, 8'h2, 20);
        i_phase_locked = 1'b0;
        i_ref_valid = 4'h1;
        wt(1, 8'h5, 20);
        done("states");
        rst(1'b0);
        wr(8'h19, 8'h11);
        i_ref_valid = 4'h2;
        wt(0, 8'h5, 10);
        i_ref_valid = 4'h3;
        nap(8);
        chk(cur(0), 8'h5);
        i_ref_valid = 4'h1;
        wt(0, 8'h4, 10);
        wr(8'h34, 8'h01);
        i_ref_valid = 4'h3;
        nap(8);
        chk(cur(0), 8'h4);
        i_ref_valid = 4'h1;
        wr(8'h19, 8'h12);
        wr(8'h34, 8'h00);
        i_ref_valid = 4'h3;
        nap(8);
        chk(cur(0), 8'h4);
        i_ref_valid = 4'h1;
        wr(8'h34, 8'h01);
        i_ref_valid = 4'h3;
        wt(0, 8'h5, 10);
        wr(8'h19, 8'h01);
        wt(0, 8'h4, 10);
        done("queue");
        foreach (fc[i]) begin
            wr(8'h33, {4'h0, fc[i]});
            wt(0, 8'h4 + i[7:0], 10);
        end
        wr(8'h33, 8'h00);
        wt(0, 8'h4, 10);
        wr(8'h33, 8'h04);
        wt(0, 8'h5, 10);
        wr(8'h33, 8'h0f);
        wt(0, 8'h4, 10);
        done("forced");
        repeat (6) begin
            i_ref_valid = 4'h0;
            pr = 16'($random(seed));
            wr(8'h19, pr[7:0]);
            wr(8'h1b, pr[15:8]);
            i_ref_valid = 4'($random(seed));
            e = best(pr, i_ref_valid);
            if (e >= 0) wt(0, 8'h4 + e[7:0], 40);
        end
        done("random");
        i_ref_valid = 4'h0;
        wr(8'h19, 8'h21);
        i_ref_valid = 4'h3;
        wt(0, 8'h4, 40);
        wr(8'h48, 8'h60);
        run = 4'he;
        wt(0, 8'h5, 60);
        rd(8'h06);
        chk(rv & 8'h40, 8'h40);
        chk(o_tdo_flag, 8'h1);
        run = 4'hf;
        wr(8'h06, 8'hff);
        nap(12);
        chk(o_tdo_flag, 8'h0);
        wr(8'h48, 8'he0);
        run = 4'he;
        nap(40);
        chk(cur(0), 8'h4);
        rd(8'h06);
        chk(rv & 8'h40, 8'h40);
        run = 4'hf;
        done("failure");
        wr(8'h48, 8'h10);
        pin_lvl = 1'b1;
        wt(0, 8'h4, 20);
        wt(1, 8'h4, 20);
        pin_lvl = 1'b0;
        wt(0, 8'h5, 20);
        chk(o_monitor_disable, 8'h1);
        wr(8'h34, 8'h10);
        nap(3);
        chk(o_manual_holdover, 8'h1);
        done("fast");
        rst(1'b1);
        nap(30);
        chk(o_tol_one, 8'h50);
        chk(o_tol_two, 8'h50);
        chk(o_monitor_disable, 8'h1);
        wr(8'h42, 8'h12);
        rd(8'h42);
        chk(rv, 8'h12);
        rst(1'b1);
        nap(2);
        pin_lvl = 1'b0;
        nap(30);
        chk(o_monitor_disable, 8'h0);
        chk(o_tol_one, 8'h00);
        done("strap");
        print_verdict();
    end
endmodule // testbench
